// ===== lopm_map.vh
// opcode, field and exception constants for the logic ops and pair merge datapath
`ifndef LOPM_MAP_VH
`define LOPM_MAP_VH
`define LOPM_OP_SPECIAL 6'h00
`define LOPM_OP_ORCONST 6'h0d
`define LOPM_OP_FLOAT 6'h11
`define LOPM_FN_NOR 6'h27
`define LOPM_FN_OR 6'h25
`define LOPM_FN_SHIFT 6'h00
`define LOPM_FN_PAIR_LL 6'h2c
`define LOPM_FN_PAIR_LH 6'h2d
`define LOPM_FMT_PAIRED 5'h16
`define LOPM_SA_LINKWAIT 5'h05
`define LOPM_ZERO5 5'h00
`define LOPM_EXC_NONE 2'h0
`define LOPM_EXC_CPU 2'h1
`define LOPM_EXC_RI 2'h2
`endif

// ===== lopm_alu.v
// combinational logic unit for the general register operations
`timescale 1ns/1ps
module lopm_alu (
    input wire [1:0] op_sel,
    input wire [31:0] src_a,
    input wire [31:0] src_b,
    input wire [15:0] const_val,
    output reg [31:0] result
);
    // 0: inverted or, 1: or, 2: or with zero-extended constant
    always @* begin
        case (op_sel)
            2'h0: result = ~(src_a | src_b);
            2'h1: result = src_a | src_b;
            2'h2: result = src_a | {16'h0000, const_val};
            default: result = 32'h00000000;
        endcase
    end
endmodule

// ===== lopm_core.v
// decode and execute stage for logic ops, link-wait and paired merges
`timescale 1ns/1ps
`include "lopm_map.vh"
// Notes on behaviour
// - inverted or writes complement of the two sources' or.
// - inverted or decodes from opcode zero, bits 10..6 zero, function 100111.
// - register or decodes from opcode zero, bits 10..6 zero, function 100101.
// - register or writes source or, with no exception.
// - or-with-constant decodes from opcode 001101 with fields 25..21, 20..16, 15..0.
// - constant is zero-extended, ored with source, written to destination.
// - link-wait is shift encoding, all register fields zero, shift amount 00101.
// - link-wait holds the stream until flag clears or an interrupt arrives.
// - without link-wait support the encoding executes as no-operation.
// - store to the lock by another stream clears the flag, releasing wait.
// - pair low-low decodes from opcode 010001, format 10110, function 101100.
// - pair low-low result is source a low over source b low.
// - pair low-high decodes from opcode 010001, format 10110, function 101101.
// - pair low-high result is source a low over source b high.
// - paired merges are moves and raise no float exception.
// - merges raise coprocessor-unusable if disabled, reserved if unsupported.
module lopm_core #(
    parameter LINKWAIT_EN = 1,
    parameter PAIRED_EN = 1
) (
    input wire clk,
    input wire reset_n,
    input wire issue_valid,
    input wire [31:0] instr,
    input wire [31:0] greg_a,
    input wire [31:0] greg_b,
    input wire [63:0] freg_a,
    input wire [63:0] freg_b,
    input wire float_enable,
    input wire link_reservation_flag,
    input wire lock_store_other,
    input wire irq_pending,
    output reg stall_r,
    output reg done_r,
    output reg greg_we_r,
    output reg [4:0] greg_dest_r,
    output reg [31:0] greg_data_r,
    output reg freg_we_r,
    output reg [4:0] freg_dest_r,
    output reg [63:0] freg_data_r,
    output reg [1:0] exc_r,
    output reg fp_exc_r,
    output reg link_flag_view_r
);
    // =====================================================
    // field extraction
    // every field is cut from the word whatever its kind; decode picks the meaning
    wire [5:0] opcode = instr[31:26];
    wire [4:0] source_a_index = instr[25:21];
    wire [4:0] source_b_index = instr[20:16];
    wire [4:0] dest_index = instr[15:11];
    wire [4:0] shamt = instr[10:6];
    wire [5:0] funct = instr[5:0];
    wire [4:0] float_fmt = instr[25:21];
    wire [4:0] float_dest = instr[10:6];
    wire [15:0] const_field = instr[15:0];
    localparam ST_RUN = 1'b0;
    localparam ST_WAIT = 1'b1;
    reg state_r;
    reg state_nxt;

    // =====================================================
    // decode
    // plain shift words other than link-wait fall through to a bare retire
    wire is_special = opcode == `LOPM_OP_SPECIAL;
    wire shamt_zero = shamt == `LOPM_ZERO5;
    wire dec_nor = is_special && shamt_zero && funct == `LOPM_FN_NOR;
    wire dec_or = is_special && shamt_zero && funct == `LOPM_FN_OR;
    wire dec_orc = opcode == `LOPM_OP_ORCONST;
    wire wait_regs_zero = source_a_index == `LOPM_ZERO5
        && source_b_index == `LOPM_ZERO5 && dest_index == `LOPM_ZERO5;
    wire dec_wait = is_special && wait_regs_zero
        && shamt == `LOPM_SA_LINKWAIT && funct == `LOPM_FN_SHIFT;
    wire is_paired = opcode == `LOPM_OP_FLOAT && float_fmt == `LOPM_FMT_PAIRED;
    wire dec_pll = is_paired && funct == `LOPM_FN_PAIR_LL;
    wire dec_plh = is_paired && funct == `LOPM_FN_PAIR_LH;
    wire dec_logic = dec_nor || dec_or || dec_orc;
    wire dec_merge = dec_pll || dec_plh;
    // build options; a wait that is not built retires like any other word
    wire wait_built = LINKWAIT_EN != 0;
    wire merge_built = PAIRED_EN != 0;

    // =====================================================
    // logic unit
    // selector falls to the constant form, which only counts when dec_orc is set
    wire [1:0] alu_sel = dec_nor ? 2'h0 : (dec_or ? 2'h1 : 2'h2);
    wire [31:0] alu_out;
    lopm_alu u_alu (
        .op_sel(alu_sel),
        .src_a(greg_a),
        .src_b(greg_b),
        .const_val(const_field),
        .result(alu_out)
    );
    // the constant form writes the second index field, the register forms the third
    wire [4:0] greg_target = dec_orc ? source_b_index : dest_index;
    wire greg_keep = greg_target != `LOPM_ZERO5;

    // =====================================================
    // paired merge
    // freg_a holds the first (upper) source, freg_b the second
    // sixteen-register mode is not seen here; the issuer keeps merges out of it
    wire [31:0] merge_hi = freg_a[31:0];
    wire [31:0] merge_lo = dec_pll ? freg_b[31:0] : freg_b[63:32];
    wire [63:0] merge_out = {merge_hi, merge_lo};
    // unusable outranks reserved, so a disabled unit never reveals what is built
    wire [1:0] merge_exc = !float_enable ? `LOPM_EXC_CPU
        : (!merge_built ? `LOPM_EXC_RI : `LOPM_EXC_NONE);
    wire merge_ok = merge_exc == `LOPM_EXC_NONE;

    // =====================================================
    // wake logic
    // a remote lock store clears the flag as seen here in the same cycle,
    // even while the flag input still lags; the input rules again next cycle
    // wake is combinational, so a wait whose flag is already clear never stalls
    wire flag_seen = link_reservation_flag && !lock_store_other;
    wire wake = !flag_seen || irq_pending;
    wire taken = issue_valid && state_r == ST_RUN;

    // =====================================================
    // wait state machine; a wait that wakes at once never stalls
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (taken && dec_wait && wait_built && !wake) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // =====================================================
    // state, stall and flag view; issues offered while waiting are dropped
    // the issuer must watch stall_r, nothing is queued behind a wait
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_RUN;
            stall_r <= 1'b0;
            link_flag_view_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            stall_r <= state_nxt == ST_WAIT;
            link_flag_view_r <= flag_seen;
        end
    end

    // =====================================================
    // retire pulse: one cycle per accepted word, or on leaving the wait
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
        end else if (state_r == ST_WAIT) begin
            done_r <= wake; // resume at the following instruction
        end else begin
            done_r <= taken && state_nxt == ST_RUN; // no-op when unsupported
        end
    end

    // =====================================================
    // general register write port; data and index hold until the next logic op, even one dropped for register zero
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            greg_we_r <= 1'b0;
            greg_dest_r <= 5'h00;
            greg_data_r <= 32'h00000000;
        end else begin
            greg_we_r <= 1'b0;
            if (taken && dec_logic) begin
                // writes to register zero are dropped
                greg_we_r <= greg_keep;
                greg_dest_r <= greg_target;
                greg_data_r <= alu_out;
            end
        end
    end

    // =====================================================
    // float register write port; merges are moves and never flag a float fault
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freg_we_r <= 1'b0;
            freg_dest_r <= 5'h00;
            freg_data_r <= 64'h0000000000000000;
            fp_exc_r <= 1'b0;
        end else begin
            freg_we_r <= 1'b0;
            fp_exc_r <= 1'b0;
            if (taken && dec_merge && merge_ok) begin
                freg_we_r <= 1'b1;
                freg_dest_r <= float_dest;
                freg_data_r <= merge_out;
            end
        end
    end

    // =====================================================
    // exception pulse; only the merges can fault, the logic forms never do
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exc_r <= `LOPM_EXC_NONE;
        end else if (taken && dec_merge) begin
            exc_r <= merge_exc;
        end else begin
            exc_r <= `LOPM_EXC_NONE;
        end
    end
endmodule

// ===== lopm_pipe.sv
// far-side model: register file view feeding the operand ports
`timescale 1ns/1ps
module lopm_pipe (
    input wire [63:0] salt,
    input wire [31:0] instr,
    output wire [31:0] greg_a,
    output wire [31:0] greg_b,
    output wire [63:0] freg_a,
    output wire [63:0] freg_b
);
    // operands hashed from the index; no delay slots, 32 float registers
    assign greg_a = salt[31:0] ^ {27'h0, instr[25:21]};
    assign greg_b = salt[63:32] ^ {27'h0, instr[20:16]};
    assign freg_a = {salt[31:0], salt[63:32]} ^ {59'h0, instr[15:11]};
    assign freg_b = ~salt ^ {59'h0, instr[20:16]};
endmodule

// ===== lopm_asserts.sv
// timing and value checks on the logic ops and pair merge core
`timescale 1ns/1ps
module lopm_asserts (
    input wire clk,
    input wire reset_n,
    input wire issue_valid,
    input wire [31:0] instr,
    input wire [31:0] greg_a,
    input wire [31:0] greg_b,
    input wire [63:0] freg_a,
    input wire [63:0] freg_b,
    input wire float_enable,
    input wire link_reservation_flag,
    input wire lock_store_other,
    input wire irq_pending,
    input wire stall_r,
    input wire done_r,
    input wire greg_we_r,
    input wire [31:0] greg_data_r,
    input wire [63:0] freg_data_r,
    input wire [1:0] exc_r,
    input wire fp_exc_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    reg [31:0] i_r, a_r, b_r;
    reg [63:0] fa_r, fb_r;
    reg t_r, en_r;
    wire sp = i_r[31:26] == 6'h00 && i_r[10:6] == 5'h00;
    wire pr = t_r && en_r && i_r[31:21] == 11'h236;
    // capture of the accepted request, compared with the answer a cycle later
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) t_r <= 1'b0;
        else t_r <= issue_valid && !stall_r;
    end
    always @(posedge clk) begin
        {i_r, a_r, b_r, fa_r, fb_r, en_r} <= {instr, greg_a, greg_b, freg_a, freg_b, float_enable};
    end
    nor_value_a: assert property (
        t_r && sp && i_r[5:0] == 6'h27 && i_r[15:11] != 5'h00 |->
        greg_we_r && greg_data_r == ~(a_r | b_r)) else $error("nor result wrong");
    or_value_a: assert property (
        t_r && sp && i_r[5:0] == 6'h25 && i_r[15:11] != 5'h00 |->
        greg_we_r && exc_r == 2'h0 && greg_data_r == (a_r | b_r)) else $error("or result wrong");
    or_const_a: assert property (
        t_r && i_r[31:26] == 6'h0d && i_r[20:16] != 5'h00 |->
        greg_we_r && greg_data_r == (a_r | {16'h0000, i_r[15:0]}))
        else $error("or with constant wrong");
    dest_zero_a: assert property (
        t_r && i_r[31:26] == 6'h0d && i_r[20:16] == 5'h00 |->
        done_r && !greg_we_r) else $error("write to register zero");
    pair_ll_a: assert property (
        pr && i_r[5:0] == 6'h2c |->
        freg_data_r == {fa_r[31:0], fb_r[31:0]}) else $error("low-low merge bad");
    pair_lh_a: assert property (
        pr && i_r[5:0] == 6'h2d |->
        freg_data_r == {fa_r[31:0], fb_r[63:32]}) else $error("low-high merge bad");
    merge_off_a: assert property (
        t_r && !en_r && i_r[31:21] == 11'h236 && i_r[5:1] == 5'h16
        |-> exc_r == 2'h1) else $error("no unusable exception");
    no_fp_exc_a: assert property (
        fp_exc_r == 1'b0) else $error("float exception raised");
    wait_hold_a: assert property (
        issue_valid && !stall_r && instr == 32'h00000140 &&
        link_reservation_flag && !lock_store_other && !irq_pending |=> stall_r && !done_r)
        else $error("link-wait did not hold");
    wait_wake_a: assert property (
        stall_r && !(link_reservation_flag && !lock_store_other && !irq_pending)
        |=> !stall_r && done_r) else $error("link-wait not released");
endmodule
bind lopm_core lopm_asserts u_chk (.clk, .reset_n, .issue_valid, .instr, .greg_a, .greg_b,
    .freg_a, .freg_b, .float_enable, .link_reservation_flag, .lock_store_other, .irq_pending,
    .stall_r, .done_r, .greg_we_r, .greg_data_r, .freg_data_r, .exc_r, .fp_exc_r);

// ===== lopm_core_tb.sv
// self-checking bench for the logic ops and pair merge core
`timescale 1ns/1ps
module lopm_core_tb;
    reg clk = 0, reset_n = 0, iv = 0, fen = 1, flag = 0, lso = 0, irq = 0;
    reg [31:0] instr = 0;
    reg [63:0] salt = 0, e;
    wire [31:0] ga, gb, gd;
    wire [63:0] fa, fb, fres;
    wire st, dn, gw, fwe, fpx, lfv;
    wire [4:0] gdst, fdst;
    wire [1:0] ex;
    integer failures = 0, n_checks = 0, cyc = 0, k, kd;
    always #20 clk = ~clk;
    lopm_pipe u_pipe (.salt(salt), .instr(instr), .greg_a(ga), .greg_b(gb), .freg_a(fa),
        .freg_b(fb));
    lopm_core u_dut (.clk(clk), .reset_n(reset_n), .issue_valid(iv), .instr(instr), .greg_a(ga),
        .greg_b(gb), .freg_a(fa), .freg_b(fb), .float_enable(fen), .link_reservation_flag(flag),
        .lock_store_other(lso), .irq_pending(irq), .stall_r(st), .done_r(dn), .greg_we_r(gw),
        .greg_dest_r(gdst), .greg_data_r(gd), .freg_we_r(fwe), .freg_dest_r(fdst),
        .freg_data_r(fres), .exc_r(ex), .fp_exc_r(fpx), .link_flag_view_r(lfv));
    // instruction word per kind; register fields come from r
    function [31:0] word(input integer t, input [31:0] r);
        case (t)
            0: word = {6'h00, r[20:6], 11'h027};
            1: word = {6'h00, r[20:6], 11'h025};
            2: word = {6'h0d, r[25:0]};
            3: word = {11'h236, r[15:1], 6'h2c};
            default: word = {11'h236, r[15:1], 6'h2d};
        endcase
    endfunction
    function [63:0] exp_val(input integer t);
        case (t)
            0: exp_val = {32'h0, ~(ga | gb)};
            1: exp_val = {32'h0, ga | gb};
            2: exp_val = {32'h0, ga | {16'h0000, instr[15:0]}};
            3: exp_val = {fa[31:0], fb[31:0]};
            default: exp_val = {fa[31:0], fb[63:32]};
        endcase
    endfunction
    task chk(input [8*6-1:0] nm, input [63:0] ev, input [63:0] sv);
        n_checks = n_checks + 1;
        if (sv !== ev) begin
            failures = failures + 1;
            $display("wrong value %0s exp %h got %h", nm, ev, sv);
        end
    endtask
    task complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard, well above the ~620 cycles the run needs
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            failures = failures + 1;
            complete_run;
        end
    end
    // random ops, one every other cycle; first five use all-zero fields as corner cases
    initial begin
        k = $urandom(32'hb990);
        repeat (2) @(posedge clk);
        reset_n <= 1;
        for (k = 0; k < 300; k = k + 1) begin
            kd = k % 5;
            @(posedge clk);
            iv <= 1;
            instr <= word(kd, k < 5 ? 32'h0 : $urandom);
            salt <= {$urandom, $urandom};
            fen <= k % 7 != 3;
            @(posedge clk);
            e = exp_val(kd);
            iv <= 0;
            #1;
            if (kd > 2 && !fen) chk("exc", 64'h1, ex);
            else if (kd < 3 && (kd == 2 ? instr[20:16] : instr[15:11]) == 5'h00)
                chk("we", 64'h0, gw);
            else chk("data", e, kd < 3 ? {32'h0, gd} : fres);
            chk("done", 64'h1, dn);
            if (kd < 3 || fen) chk("noexc", 64'h0, {fpx, ex});
            if (kd > 2) chk("fwe", {63'h0, fen}, fwe);
            if (kd > 2 && fen) chk("fdst", {59'h0, instr[10:6]}, fdst);
            if (kd < 3)
                chk("gdst", {59'h0, kd == 2 ? instr[20:16] : instr[15:11]}, gdst);
        end
        // link-wait released by a foreign store, an interrupt, then the flag itself
        for (k = 0; k < 3; k = k + 1) begin
            @(posedge clk);
            iv <= 1;
            instr <= 32'h00000140;
            flag <= 1;
            @(posedge clk);
            instr <= 32'h00221825;
            #1 chk("view", 64'h1, lfv);
            repeat (3) @(posedge clk);
            iv <= 0;
            lso <= k == 0;
            irq <= k == 1;
            flag <= k != 2;
            #1 chk("stall", 64'h1, st);
            chk("we", 64'h0, gw);
            @(posedge clk);
            {lso, irq, flag} <= 3'h0;
            #1 chk("done", 64'h1, {st, dn});
            chk("view", {63'h0, k == 1}, lfv);
        end
        // link-wait with the flag already clear retires at once
        @(posedge clk);
        iv <= 1;
        instr <= 32'h00000140;
        @(posedge clk);
        iv <= 0;
        #1 chk("nowait", 64'h1, {st, dn});
        complete_run;
    end
endmodule
